//--- wdcg_pkg.sv
// wdcg_pkg: constants shared by the watchdog configuration guard files.
// assumes a 40 MHz core clock and a 32-bit avalon-mm register bus.
package wdcg_pkg;

  // bus geometry
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 32;
  localparam int          BE_W         = DATA_W / 8;

  // register byte addresses
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;

  // control register field positions
  localparam int          CTRL_CE_BIT  = 4;
  localparam int          CTRL_EN_BIT  = 3;
  localparam int          CTRL_PS_LSB  = 0;
  localparam int          PS_W         = 3;

  // status register field positions
  localparam int          STAT_WIN_BIT = 0;
  localparam int          STAT_LVL_LSB = 1;
  localparam int          STAT_EN_BIT  = 3;

  // safety level encodings
  localparam int          LVL_W        = 2;
  localparam logic [1:0]  LVL_0        = 2'h0;
  localparam logic [1:0]  LVL_1        = 2'h1;
  localparam logic [1:0]  LVL_2        = 2'h2;

  // change window length in core clock cycles
  localparam int          WIN_CNT_W    = 3;
  localparam logic [2:0]  WIN_CYCLES   = 3'h4;

  // time-out in watchdog oscillator cycles
  localparam int          TMO_W        = 22;
  localparam logic [21:0] TMO_BASE     = 22'h004000;

  // reset values
  localparam logic [2:0]  PS_RESET     = 3'h0;

endpackage

//--- wdcg_period_decode.sv
// wdcg_period_decode: maps the period select code to a time-out length.
// assumes a registered select code; output is purely combinational.
module wdcg_period_decode (
  // period select
  input  wire logic [wdcg_pkg::PS_W-1:0]  sel_i,
  // time-out length in watchdog oscillator cycles
  output logic      [wdcg_pkg::TMO_W-1:0] cycles_o
);
  import wdcg_pkg::*;

  // base count doubled once per code step
  always_comb begin
    cycles_o = TMO_BASE << sel_i;
  end

endmodule

//--- wdcg_guard.sv
// wdcg_guard: write-protection of the watchdog enable and period select.
// assumes a static safety level strap and an avalon-mm master on core_clk_i.
//
// Contract
// - three safety levels, each with own conditions
// - level 0: disabled at reset, enable freely
// - level 0: period select written freely
// - level 0: disable needs timed two-step sequence
// - level 1: disabled at reset, enable freely
// - level 1: disable or period change timed
// - level 1: second write within four cycles applies
// - level 2: always enabled, reads one
// - level 2: second write sets period only
// - change bit self-clears after four cycles
// - period code selects 16K doubling time-outs
//
// Register access over Avalon-MM and the address map are this design's own decisions.
module wdcg_guard (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  // avalon-mm slave
  input  wire logic [wdcg_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [wdcg_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [wdcg_pkg::BE_W-1:0]     avs_byteenable_i,
  output logic      [wdcg_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  // static configuration
  input  wire logic [wdcg_pkg::LVL_W-1:0]    safety_level_i,
  // watchdog timer controls
  output logic                               wdog_enable_o,
  output logic      [wdcg_pkg::PS_W-1:0]     wdog_period_select_o,
  output logic      [wdcg_pkg::TMO_W-1:0]    wdog_timeout_cycles_o
);
  import wdcg_pkg::*;

  logic [LVL_W-1:0]     lvl_meta_q;
  logic [LVL_W-1:0]     lvl_q;
  logic                 wait_q;
  logic                 wait_d;
  logic [DATA_W-1:0]    rdata_q;
  logic [DATA_W-1:0]    rdata_d;
  logic                 en_q;
  logic                 en_d;
  logic [PS_W-1:0]      ps_q;
  logic [PS_W-1:0]      ps_d;
  logic [WIN_CNT_W-1:0] win_cnt_q;
  logic [WIN_CNT_W-1:0] win_cnt_d;
  logic [TMO_W-1:0]     tmo_q;
  logic [TMO_W-1:0]     tmo_comb;
  logic                 win_open;
  logic                 wr_take;
  logic                 ce_w;
  logic                 en_w;
  logic [PS_W-1:0]      ps_w;
  logic                 open_req;
  logic                 lvl_locked;
  logic                 lvl_always;

  // the strap is static but still crosses in through two flops
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lvl_meta_q <= LVL_0;
      lvl_q      <= LVL_0;
    end else begin
      lvl_meta_q <= safety_level_i;
      lvl_q      <= lvl_meta_q;
    end
  end

  // write decode and level classes; codes above 2 act as level 2
  always_comb begin
    wr_take    = avs_write_i && !wait_q && (avs_address_i == ADDR_CTRL) && avs_byteenable_i[0];
    ce_w       = avs_writedata_i[CTRL_CE_BIT];
    en_w       = avs_writedata_i[CTRL_EN_BIT];
    ps_w       = avs_writedata_i[CTRL_PS_LSB +: PS_W];
    open_req   = ce_w && en_w;
    win_open   = (win_cnt_q != '0);
    lvl_always = (lvl_q >= LVL_2);
    lvl_locked = (lvl_q != LVL_0);
  end

  // bus handshake: one wait cycle, then a one-cycle answer
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = '0;
    if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_d = 1'b0;
      if (avs_address_i == ADDR_CTRL) begin
        rdata_d[CTRL_CE_BIT]                = win_open;
        rdata_d[CTRL_EN_BIT]                = en_q;
        rdata_d[CTRL_PS_LSB +: PS_W]        = ps_q;
      end else if (avs_address_i == ADDR_STATUS) begin
        rdata_d[STAT_WIN_BIT]               = win_open;
        rdata_d[STAT_LVL_LSB +: LVL_W]      = lvl_q;
        rdata_d[STAT_EN_BIT]                = en_q;
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // change window: an opening write reloads, a write with ce clear closes it, otherwise count down
  always_comb begin
    win_cnt_d = win_cnt_q;
    if (wr_take && open_req) begin
      win_cnt_d = WIN_CYCLES;
    end else if (wr_take && !ce_w && win_open) begin
      win_cnt_d = '0;
    end else if (win_open) begin
      win_cnt_d = win_cnt_q - 3'h1;
    end
  end

  // enable and period select under the level's protection
  always_comb begin
    en_d = en_q;
    ps_d = ps_q;
    if (wr_take) begin
      if (en_w) begin
        en_d = 1'b1;
      end else if (win_open) begin
        en_d = 1'b0;
      end
      if (!lvl_locked) begin
        ps_d = ps_w;
      end else if (win_open && !ce_w) begin
        ps_d = ps_w;
      end
    end
    if (lvl_always) begin
      en_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      win_cnt_q <= '0;
      en_q      <= 1'b0;
      ps_q      <= PS_RESET;
      tmo_q     <= TMO_BASE;
    end else begin
      win_cnt_q <= win_cnt_d;
      en_q      <= en_d;
      ps_q      <= ps_d;
      tmo_q     <= tmo_comb;
    end
  end

  wdcg_period_decode u_period_decode (
    .sel_i    (ps_q),
    .cycles_o (tmo_comb)
  );

  // outputs straight from flops
  assign avs_readdata_o        = rdata_q;
  assign avs_waitrequest_o     = wait_q;
  assign wdog_enable_o         = en_q;
  assign wdog_period_select_o  = ps_q;
  assign wdog_timeout_cycles_o = tmo_q;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_window_opens_four: assert property (
    (wr_take && open_req) ##1 (!wr_take)[*3] |-> ($past(win_cnt_q, 2) == WIN_CYCLES) && win_open ##1 win_open
  ) else $error("change window not open for four cycles");

  a_window_self_close: assert property (
    (win_cnt_q == 3'h1 && !(wr_take && open_req)) |=> !win_open
  ) else $error("change window did not close");

  a_level2_always_on: assert property (
    (lvl_q >= LVL_2) |=> en_q
  ) else $error("level 2 watchdog not enabled");

  a_enable_set_free: assert property (
    (wr_take && en_w) |=> en_q
  ) else $error("enable write not honoured");

  a_disable_needs_window: assert property (
    (wr_take && !en_w && !win_open) |=> (en_q == $past(en_q))
  ) else $error("enable cleared outside window");

  a_level1_ps_locked: assert property (
    (wr_take && lvl_q == LVL_1 && !win_open) |=> $stable(ps_q)
  ) else $error("period changed without sequence");

  a_level0_ps_free: assert property (
    (wr_take && lvl_q == LVL_0) |=> (ps_q == $past(ps_w))
  ) else $error("level 0 period write lost");

  a_level2_ps_seq: assert property (
    (wr_take && lvl_q == LVL_2 && win_open && !ce_w) |=> (ps_q == $past(ps_w)) && en_q
  ) else $error("level 2 period change not applied");

  a_level1_disable_seq: assert property (
    (wr_take && lvl_q == LVL_1 && win_open && !ce_w) |=> (en_q == $past(en_w)) && !win_open
  ) else $error("level 1 second write not applied");

  a_timeout_map: assert property (
    1'b1 |=> (tmo_q == (TMO_BASE << $past(ps_q)))
  ) else $error("time-out length mismatch");

endmodule

//--- wdcg_guard_tb.sv
// wdcg_guard_tb: self-checking bench for the watchdog configuration guard.
// assumes wdcg_pkg and wdcg_guard are compiled first; the bench is the bus master.
module wdcg_guard_tb import wdcg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  logic [ADDR_W-1:0] addr     = '0;
  logic              rd       = 1'b0;
  logic              wr       = 1'b0;
  logic [DATA_W-1:0] wdata    = '0;
  logic [BE_W-1:0]   be       = 4'hf;
  logic [LVL_W-1:0]  level    = LVL_0;
  logic [DATA_W-1:0] rdata;
  logic              wait_req;
  logic              wd_en;
  logic [PS_W-1:0]   wd_ps;
  logic [TMO_W-1:0]  wd_tmo;
  int                bad_count = 0;
  int                checks    = 0;
  int                cyc       = 0;

  wdcg_guard dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .safety_level_i(level), .wdog_enable_o(wd_en),
    .wdog_period_select_o(wd_ps), .wdog_timeout_cycles_o(wd_tmo));

  // 40 mhz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] ctl(input logic ce, input logic en, input logic [2:0] ps);
    return {27'h0, ce, en, ps};
  endfunction

  // one access, left asserted so another can follow back to back
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    wr    <= w;
    rd    <= ~w;
    addr  <= a;
    wdata <= d;
    do begin
      @(posedge core_clk);
    end while (wait_req !== 1'b0);
    q = rdata;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rreg(input logic [3:0] a, input string what, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask

  task automatic idle(input int n);
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  // settle, then compare the timer controls
  task automatic outs(input logic en, input logic [2:0] ps);
    idle(2);
    chk("enable", 32'(wd_en), 32'(en));
    chk("period", 32'(wd_ps), 32'(ps));
    chk("timeout", 32'(wd_tmo), 32'(TMO_BASE) << ps);
  endtask

  task automatic restart(input logic [1:0] l);
    rst_n <= 1'b0;
    level <= l;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  // test sequence, one safety level after another
  initial begin
    restart(LVL_0);
    outs(1'b0, 3'h0);
    rreg(ADDR_STATUS, "status", 32'h0);
    for (int c = 0; c < 8; c++) begin
      wreg(ADDR_CTRL, ctl(1'b0, 1'b1, 3'(c)));
      outs(1'b1, 3'(c));
    end
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h2));
    outs(1'b1, 3'h2);
    be <= 4'he;
    wreg(ADDR_CTRL, ctl(1'b0, 1'b1, 3'h5));
    outs(1'b1, 3'h2);
    be <= 4'hf;
    wreg(4'h8, ctl(1'b0, 1'b1, 3'h5));
    outs(1'b1, 3'h2);
    rreg(4'h8, "unmapped", 32'h0);
    wreg(ADDR_CTRL, ctl(1'b1, 1'b1, 3'h2));
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h2));
    outs(1'b0, 3'h2);
    rreg(ADDR_CTRL, "control", ctl(1'b0, 1'b0, 3'h2));
    idle(1);
    $display("test level 0 done");
    restart(LVL_1);
    outs(1'b0, 3'h0);
    wreg(ADDR_CTRL, ctl(1'b0, 1'b1, 3'h3));
    outs(1'b1, 3'h0);
    wreg(ADDR_CTRL, ctl(1'b1, 1'b1, 3'h3));
    rreg(ADDR_CTRL, "window", ctl(1'b1, 1'b1, 3'h0));
    idle(6);
    rreg(ADDR_CTRL, "window", ctl(1'b0, 1'b1, 3'h0));
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h6));
    outs(1'b1, 3'h0);
    wreg(ADDR_CTRL, ctl(1'b1, 1'b1, 3'h0));
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h6));
    outs(1'b0, 3'h6);
    rreg(ADDR_STATUS, "status", 32'h2);
    idle(1);
    $display("test level 1 done");
    restart(LVL_2);
    outs(1'b1, 3'h0);
    rreg(ADDR_CTRL, "control", ctl(1'b0, 1'b1, 3'h0));
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h7));
    outs(1'b1, 3'h0);
    wreg(ADDR_CTRL, ctl(1'b1, 1'b1, 3'h0));
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h7));
    outs(1'b1, 3'h7);
    rreg(ADDR_STATUS, "status", 32'hc);
    idle(1);
    $display("test level 2 done");
    restart(2'h3);
    outs(1'b1, 3'h0);
    wreg(ADDR_CTRL, ctl(1'b0, 1'b0, 3'h5));
    outs(1'b1, 3'h0);
    rreg(ADDR_STATUS, "status", 32'he);
    idle(1);
    $display("test level 3 done");
    end_sim();
  end
endmodule
